//--- rtl/pcasr_pkg.sv
`default_nettype none
package pcasr_pkg;
    // Register map and field layout of the power control word.
    localparam logic [7:0]  PCASR_OFF_CTRL1     = 8'h36;
    localparam logic [31:0] PCASR_CTRL1_RESET   = 32'h8002_0000;
    // Writable bits; reserved bits are held at their reset value.
    localparam logic [31:0] PCASR_CTRL1_WMASK   = 32'hfc02_fffa;
    localparam int          PCASR_BIT_RX2INIT   = 1;
    localparam int          PCASR_PACKET_SEQUENCING_FIELD_LSB    = 3;
    localparam int          PCASR_PACKET_SEQUENCING_FIELD_MSB    = 10;
    localparam int          PCASR_BIT_SLP_TX    = 11;
    localparam int          PCASR_BIT_SLP_RX    = 12;
    localparam int          PCASR_BIT_SNOOZE    = 13;
    localparam int          PCASR_BIT_SNOOZE_R  = 14;
    localparam int          PCASR_BIT_SYNC_CLK  = 15;
    localparam int          PCASR_BIT_RANGING   = 17;
    localparam int          PCASR_KHZ_LSB       = 26;
    localparam int          PCASR_KHZ_MSB       = 31;
    // Status word of the automatic transition logic.
    localparam logic [7:0]  PCASR_OFF_STATUS    = 8'h38;
    localparam logic [31:0] PCASR_STATUS_RESET  = 32'h0000_0000;
endpackage : pcasr_pkg
`default_nettype wire

//--- rtl/pcasr_power_ctrl.sv
// Added by the designer: the address-and-strobe port.
`default_nettype none
module pcasr_power_ctrl (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    input  wire logic        rx_done_i,
    input  wire logic        tx_done_i,
    input  wire logic        wake_i,
    input  wire logic [31:0] irq_status_i,
    input  wire logic [31:0] irq_mask_i,
    input  wire logic        preserve_sleep_setting_i,
    input  wire logic        sleep_enable_i,
    output logic             go_init_o,
    output logic             go_sleep_o,
    output logic             rf_seq_enable_o,
    output logic [7:0]       packet_sequencing_field_o,
    output logic             snooze_enable_o,
    output logic             snooze_repeat_o,
    output logic             sync_clock_enable_o,
    output logic             ranging_engine_run_enable_o,
    output logic [5:0]       kilohertz_divider_field_o
);
    // Control word as held, and the value it takes at the next edge.
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    // Snapshot of the last automatic decisions, readable at the status offset.
    logic [31:0] stat_q;
    // Decoded conditions of the current cycle.
    logic        pend;
    logic        want_init;
    logic        want_sleep;
    logic        wr_ctrl;
    logic        rd_ctrl;
    logic        rd_stat;

    // The block sits behind the register bank of the power management controller.
    // Software owns the control word; the hardware only ever clears the two
    // automatic sleep controls, and only on a wake-up event.
    // The transceiver reports the end of a receive attempt and of a frame
    // transmission as one-cycle pulses on the core clock, so no synchroniser
    // is placed in front of them.
    // The interrupt status and mask are levels from the same clock domain.
    // A decision is made in the cycle of the event and shown one cycle later
    // as a registered pulse, so downstream sequencing sees a clean edge.
    // The divider, snooze, synchronisation clock and ranging engine fields are
    // only stored and passed on; their behaviour lives elsewhere.

    // True when the bus address selects the given register offset.
    function automatic logic pcasr_hit(input logic [7:0] addr, input logic [7:0] offset);
        return addr == offset;
    endfunction

    // Packet sequencing field of a control word.
    function automatic logic [7:0] pcasr_seq(input logic [31:0] word);
        return word[pcasr_pkg::PCASR_PACKET_SEQUENCING_FIELD_MSB:pcasr_pkg::PCASR_PACKET_SEQUENCING_FIELD_LSB];
    endfunction

    // Kilohertz divider field of a control word.
    function automatic logic [5:0] pcasr_khz(input logic [31:0] word);
        return word[pcasr_pkg::PCASR_KHZ_MSB:pcasr_pkg::PCASR_KHZ_LSB];
    endfunction

    // Merges a write into the control word; reserved bits keep their stored value.
    // Software is expected to write reserved bits back unchanged, but the mask
    // protects the word even if it does not.
    function automatic logic [31:0] pcasr_merge(input logic [31:0] old_word, input logic [31:0] new_word);
        return (new_word & pcasr_pkg::PCASR_CTRL1_WMASK) | (old_word & ~pcasr_pkg::PCASR_CTRL1_WMASK);
    endfunction

    // Only unmasked interrupts block an automatic transition.
    // A masked event must never keep the device awake or out of the initial state.
    assign pend = |(irq_status_i & irq_mask_i);

    // Return to the initial state after a receive attempt.
    // It loses to sleep after receive when both are armed, so the device never
    // gets two conflicting moves in one cycle.
    assign want_init = ctrl_q[pcasr_pkg::PCASR_BIT_RX2INIT] & rx_done_i & ~pend;

    // Automatic sleep after a frame transmission or after a receive attempt.
    // Sleep after transmit also needs the always-on sleep enable; without it
    // the request is dropped and the device stays awake.
    assign want_sleep = ~pend & ((ctrl_q[pcasr_pkg::PCASR_BIT_SLP_TX] & tx_done_i & sleep_enable_i)
                      | (ctrl_q[pcasr_pkg::PCASR_BIT_SLP_RX] & rx_done_i));

    // Register bus decode; the bus never waits, so every strobe is taken at once.
    assign wr_ctrl = reg_wr_i & pcasr_hit(reg_addr_i, pcasr_pkg::PCASR_OFF_CTRL1);
    assign rd_ctrl = reg_rd_i & pcasr_hit(reg_addr_i, pcasr_pkg::PCASR_OFF_CTRL1);
    assign rd_stat = reg_rd_i & pcasr_hit(reg_addr_i, pcasr_pkg::PCASR_OFF_STATUS);

    // Next control word: writes touch writable bits only; wake clears auto sleep unless the preserve setting is high.
    // The wake clear is applied after the write so that it wins when both fall
    // in one cycle; otherwise a stale write could re-arm sleep right after waking.
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = pcasr_merge(ctrl_q, reg_wdata_i);
        end
        if (wake_i && !preserve_sleep_setting_i) begin
            ctrl_d[pcasr_pkg::PCASR_BIT_SLP_TX] = 1'b0;
            ctrl_d[pcasr_pkg::PCASR_BIT_SLP_RX] = 1'b0;
        end
    end

    // Control word register.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ctrl_q <= pcasr_pkg::PCASR_CTRL1_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Transition pulses and status snapshot of the last decisions.
    // Each pulse stands for exactly one cycle because the inputs are pulses.
    // The status word keeps the decision of the previous cycle for software.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            go_init_o  <= 1'b0;
            go_sleep_o <= 1'b0;
            stat_q     <= pcasr_pkg::PCASR_STATUS_RESET;
        end else begin
            go_init_o  <= want_init & ~want_sleep;
            go_sleep_o <= want_sleep;
            stat_q     <= {29'h0000_0000, pend, want_sleep, want_init & ~want_sleep};
        end
    end

    // Field outputs follow the control word.
    // They are taken from the next value so they settle one cycle after a write,
    // the same cycle in which a read would first see the new word.
    // The sequencing enable is a plain nonzero test of the field: a zero hands
    // control of the analog blocks back to software.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rf_seq_enable_o             <= 1'b0;
            packet_sequencing_field_o   <= 8'h00;
            snooze_enable_o             <= 1'b0;
            snooze_repeat_o             <= 1'b0;
            sync_clock_enable_o         <= 1'b0;
            ranging_engine_run_enable_o <= 1'b0;
            kilohertz_divider_field_o   <= 6'h00;
        end else begin
            rf_seq_enable_o             <= |pcasr_seq(ctrl_d);
            packet_sequencing_field_o   <= pcasr_seq(ctrl_d);
            snooze_enable_o             <= ctrl_d[pcasr_pkg::PCASR_BIT_SNOOZE];
            snooze_repeat_o             <= ctrl_d[pcasr_pkg::PCASR_BIT_SNOOZE_R];
            sync_clock_enable_o         <= ctrl_d[pcasr_pkg::PCASR_BIT_SYNC_CLK];
            ranging_engine_run_enable_o <= ctrl_d[pcasr_pkg::PCASR_BIT_RANGING];
            kilohertz_divider_field_o   <= pcasr_khz(ctrl_d);
        end
    end

    // Read data stands one cycle after the read strobe; unmapped reads return zero.
    // Returning zero outside the read slot keeps the shared read bus quiet, so
    // several register blocks can be ORed together upstream.
    // A read in the same cycle as a write returns the word before the write.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (rd_ctrl) begin
            reg_rdata_o <= ctrl_q;
        end else if (rd_stat) begin
            reg_rdata_o <= stat_q;
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

    // Limitations a user should know.
    // The block does not check that the always-on wake configuration was set up
    // before sleep after transmit is armed; software has to do that first.
    // A wake event with the preserve setting high leaves both sleep controls
    // armed, so the next transmission or receive attempt sleeps again at once.
    // Writes to the status offset are ignored; the status word is read only.
    // Only the byte address is decoded, so aliases outside this map read zero.
endmodule // pcasr_power_ctrl
`default_nettype wire

//--- tb/pcasr_power_ctrl_chk.sv
`default_nettype none
module pcasr_power_ctrl_chk (
    input wire logic core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, rx_done_i, tx_done_i,
    input wire logic sleep_enable_i, go_init_o, go_sleep_o, rf_seq_enable_o,
    input wire logic [7:0] reg_addr_i, packet_sequencing_field_o,
    input wire logic [31:0] reg_wdata_i, reg_rdata_o, irq_status_i, irq_mask_i
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // An unmasked interrupt is waiting.
    sequence s_pend; |(irq_status_i & irq_mask_i); endsequence
    a_pend_blocks: assert property (s_pend |=> !go_sleep_o && !go_init_o) else $error("move while pending");
    a_no_cause: assert property (!rx_done_i && !tx_done_i |=> !go_sleep_o && !go_init_o) else $error("no event");
    a_tx_enable: assert property (tx_done_i && !rx_done_i && !sleep_enable_i |=> !go_sleep_o)
        else $error("sleep without enable");
    a_tx_no_init: assert property (tx_done_i && !rx_done_i |=> !go_init_o) else $error("init after tx");
    a_seq_gate: assert property (rf_seq_enable_o == (packet_sequencing_field_o != 8'h00)) else $error("seq gate");
    a_rd_slot: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0) else $error("data outside slot");
    a_rd_unmapped: assert property (reg_rd_i && reg_addr_i > 8'h38 |=> reg_rdata_o == 32'h0) else $error("unmapped");
    a_seq_write: assert property (reg_wr_i && reg_addr_i == 8'h36 |=>
        packet_sequencing_field_o == $past(reg_wdata_i[10:3])) else $error("seq field");
endmodule // pcasr_power_ctrl_chk
bind pcasr_power_ctrl pcasr_power_ctrl_chk u_chk (.*);
`default_nettype wire

//--- tb/pcasr_power_ctrl_test.sv
`default_nettype none
module pcasr_power_ctrl_test;
    timeunit 1ns; timeprecision 1ps;
    logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, tx = 1'h0, rx = 1'h0, wk = 1'h0, prs = 1'h0, sen = 1'h0;
    logic gi, gs, se, p, s, sz, sr, sy, rg;
    logic [5:0] kd;
    logic [7:0] ad = 8'h00, ps;
    logic [31:0] wd = 32'h0, st = 32'h0, mk = 32'h0, rdo, m = pcasr_pkg::PCASR_CTRL1_RESET;
    int error_cnt = 0, cmp_count = 0;
`define CHK(n, x, y) begin cmp_count++; if ((y) !== (x)) begin error_cnt++; $display("[ERR] %s exp %h got %h", n, x, y); end end
    pcasr_power_ctrl DUT (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(ad), .reg_wdata_i(wd), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdo), .rx_done_i(rx), .tx_done_i(tx), .wake_i(wk), .irq_status_i(st),
        .irq_mask_i(mk), .preserve_sleep_setting_i(prs), .sleep_enable_i(sen), .go_init_o(gi), .go_sleep_o(gs),
        .rf_seq_enable_o(se), .packet_sequencing_field_o(ps), .snooze_enable_o(sz), .snooze_repeat_o(sr),
        .sync_clock_enable_o(sy), .ranging_engine_run_enable_o(rg), .kilohertz_divider_field_o(kd));
    // Bus write; the model keeps only the writable bits.
    task automatic wr_w(input logic [7:0] a, input logic [31:0] d);
        wr <= 1'h1; ad <= a; wd <= d; @(posedge clk); wr <= 1'h0;
        if (a == 8'h36) m = (m & ~pcasr_pkg::PCASR_CTRL1_WMASK) | (d & pcasr_pkg::PCASR_CTRL1_WMASK);
    endtask
    // Bus read; the word is compared with the expected value, the field outputs with the model.
    task automatic rd_w(input logic [7:0] a, input logic [31:0] x);
        rd <= 1'h1; ad <= a; @(posedge clk); rd <= 1'h0; @(negedge clk);
        `CHK("word", x, rdo)
        `CHK("seq", {|m[10:3], m[10:3]}, {se, ps})
        `CHK("fields", {m[31:26], m[17], m[15], m[14], m[13]}, {kd, rg, sy, sr, sz})
        @(posedge clk);
    endtask
    // One event pulse, then both automatic moves are checked.
    task automatic ev(input logic t, input logic r);
        tx <= t; rx <= r; @(posedge clk); tx <= 1'h0; rx <= 1'h0;
        p = |(st & mk);
        s = ((m[11] & t & sen) | (m[12] & r)) & !p;
        @(negedge clk);
        `CHK("sleep", s, gs)
        `CHK("init", m[1] & r & !p & !s, gi)
        @(posedge clk);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Core clock.
    initial forever #4 clk = ~clk;
    // Reset, map checks, then random events and wake-ups.
    initial begin
        void'($urandom(32'hf5ca));
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rd_w(8'h36, m);
        rd_w(8'h3c, 32'h0);
        wr_w(8'h38, '1);
        rd_w(8'h36, m);
        wr_w(8'h36, m | 32'h0000_073a);
        sen <= 1'h1;
        rd_w(8'h36, m);
        ev(1'h0, 1'h1);
        $display("map test done");
        for (int i = 0; i < 40; i++) begin
            wr_w(8'h36, (32'($urandom()) & pcasr_pkg::PCASR_CTRL1_WMASK) | (m & ~pcasr_pkg::PCASR_CTRL1_WMASK));
            st <= 32'h1 << $urandom_range(3, 0); mk <= $urandom(); sen <= 1'($urandom()); prs <= 1'($urandom());
            ev(1'($urandom()), 1'($urandom()));
            wk <= 1'h1; @(posedge clk); wk <= 1'h0;
            if (!prs) m[12:11] = 2'h0;
            rd_w(8'h36, m);
        end
        $display("random test done");
        finish_test();
    end
endmodule // pcasr_power_ctrl_test
`default_nettype wire
